// [rtl/ir_mod_regs.vh]
// Register map, field positions and reset values of the infrared modulator output stage
`ifndef IR_MOD_REGS_VH
`define IR_MOD_REGS_VH
`define ADDR_W 4
`define OFF_PIN_OUTPUT_CONTROL 4'h0
`define OFF_MODULATOR_STATUS_CONTROL 4'h1
`define OFF_MARK_PERIOD_HIGH 4'h2
`define OFF_MARK_PERIOD_LOW 4'h3
`define OFF_SPACE_PERIOD_HIGH 4'h4
`define OFF_SPACE_PERIOD_LOW 4'h5
`define OFF_IRQ_STATUS 4'h6
`define OFF_IRQ_ENABLE 4'h7
`define OFF_IRQ_CLEAR 4'h8
`define OFF_MOD_STATE 4'h9
`define BIT_LATCH 7
`define BIT_POL 6
`define BIT_PIN_EN 5
`define BIT_END_OF_CYCLE_FLAG 7
`define BIT_DIV_HI 6
`define BIT_DIV_LO 5
`define BIT_EXTENDED_SPACE_ENABLE 4
`define BIT_BASEBAND_SELECT 3
`define BIT_FSK 2
`define BIT_END_OF_CYCLE_IRQ_ENABLE 1
`define BIT_MODULATOR_CARRIER_ENABLE 0
`define RST_PIN_OUTPUT_CONTROL 8'h00
`define RST_MODULATOR_STATUS_CONTROL 8'h00
`define RST_MSC_CTRL 7'h00
`define RST_PERIOD 8'h00
`define IRQ_EOC 0
`define IRQ_START 1
`endif

// [rtl/clock_prescaler.v]
// Divide-by-1/2/4/8 clock-enable generator for the modulator
`timescale 1ns/1ps
module clock_prescaler (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_ce,
    input wire i_run,
    input wire [1:0] i_sel,
    output reg o_tick
);
    reg [2:0] count_reg;
    reg [2:0] limit;
    always @* begin
        case (i_sel)
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            default: limit = 3'h7;
        endcase
    end
    // Select applies at once; changing it mid-frame only shifts one tick
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            count_reg <= 3'h0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                count_reg <= 3'h0;
                o_tick <= 1'b0;
            end else if (count_reg >= limit) begin
                count_reg <= 3'h0;
                o_tick <= 1'b1;
            end else begin
                count_reg <= count_reg + 3'h1;
                o_tick <= 1'b0;
            end
        end
    end
endmodule

// [rtl/pin_sync.v]
// Three-stage synchroniser with agreement check for an off-domain input
`timescale 1ns/1ps
module pin_sync (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_ce,
    input wire i_async,
    output reg o_level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            o_level <= 1'b0;
        end else if (i_ce) begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Only the later two stages are compared; the first may be metastable
            if (s2_reg == s3_reg) begin
                o_level <= s3_reg;
            end
        end
    end
endmodule

// [rtl/ir_modulator_output_status.v]
// Infrared modulator output pin stage, status/control register and end-of-cycle logic
// How it works
// - Polarity bit 1 drives pin active high; 0 inverts the selected source.
// - Pin enabled: modulator output when enable set or a cycle still runs, else the software latch bit.
// - Pin enable 0 or reset puts the infrared pin in high impedance.
// - Flag bit 7 sets when enable rises while the modulator is idle.
// - While enabled, flag sets when down counter matches the space period register.
// - At each match, counter reloads from mark buffer, space register from space buffer.
// - Flag clears only after status read followed by access to the mark or space period low register.
// - Re-enable before the cycle ends sets no flag then; flag comes at cycle end.
// - Prescaler code in bits 6 to 5 divides the clock by 1, 2, 4 or 8.
// - Bit 4 enables extended space operation when 1.
// - Interrupt requested while the flag and its interrupt enable are both set.
// - Latch write moves pin when modulator off and pin enabled; read returns latch.
`timescale 1ns/1ps
`include "ir_mod_regs.vh"
module ir_modulator_output_status (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_ce,
    input wire [`ADDR_W-1:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    output reg [31:0] o_readdata,
    output reg o_waitrequest,
    input wire i_carrier,
    output reg o_infrared_output_pin,
    output reg o_infrared_output_pin_oe,
    output reg o_extended_space_enable,
    output reg o_frequency_shift_select,
    output reg o_baseband_select,
    output reg o_modulator_active,
    output reg o_irq
);
    reg [7:0] pin_output_control_reg;
    reg [6:0] msc_ctrl_reg;
    reg end_of_cycle_flag_reg;
    reg armed_reg;
    reg [7:0] mark_period_high_reg;
    reg [7:0] mark_period_low_reg;
    reg [7:0] space_period_high_reg;
    reg [7:0] space_period_low_reg;
    reg [15:0] down_counter_reg;
    reg [15:0] space_period_reg;
    reg active_reg;
    reg mod_out_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_enable_reg;
    reg ack_reg;
    reg [31:0] rdata_next;
    wire carrier_sync;
    wire tick;
    wire modulator_carrier_enable;
    wire access;
    wire wr_hit;
    wire rd_hit;
    wire match;
    wire start_event;
    wire eoc_event;
    wire data_24_access;
    wire tx_out;
    wire pin_src;

    function is_reg;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] off;
        begin
            is_reg = (addr == off);
        end
    endfunction

    pin_sync u_carrier_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async(i_carrier),
        .o_level(carrier_sync)
    );

    clock_prescaler u_prescaler (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_run(active_reg),
        .i_sel(msc_ctrl_reg[`BIT_DIV_HI:`BIT_DIV_LO]),
        .o_tick(tick)
    );

    assign modulator_carrier_enable = msc_ctrl_reg[`BIT_MODULATOR_CARRIER_ENABLE];
    // One wait state: every access completes at the edge after it is first seen
    assign access = (i_read | i_write) & ~ack_reg & i_ce;
    assign wr_hit = access & i_write;
    assign rd_hit = access & i_read;
    assign data_24_access = access & (is_reg(i_address, `OFF_MARK_PERIOD_LOW) |
        is_reg(i_address, `OFF_SPACE_PERIOD_LOW));
    assign match = active_reg & tick & (down_counter_reg == space_period_reg);
    assign eoc_event = match & modulator_carrier_enable;
    // A cycle still running means re-enable is no fresh start
    assign start_event = wr_hit & is_reg(i_address, `OFF_MODULATOR_STATUS_CONTROL) &
        i_writedata[`BIT_MODULATOR_CARRIER_ENABLE] & ~modulator_carrier_enable & ~active_reg;
    assign tx_out = mod_out_reg & (msc_ctrl_reg[`BIT_BASEBAND_SELECT] | carrier_sync);
    assign pin_src = (modulator_carrier_enable | active_reg) ? tx_out :
        pin_output_control_reg[`BIT_LATCH];

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            ack_reg <= 1'b0;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h00000000;
        end else if (i_ce) begin
            ack_reg <= access;
            o_waitrequest <= ~access;
            o_readdata <= access ? rdata_next : 32'h00000000;
        end
    end

    always @* begin
        rdata_next = 32'h00000000;
        case (i_address)
            `OFF_PIN_OUTPUT_CONTROL: rdata_next[7:0] = pin_output_control_reg;
            `OFF_MODULATOR_STATUS_CONTROL: rdata_next[7:0] = {end_of_cycle_flag_reg, msc_ctrl_reg};
            `OFF_MARK_PERIOD_HIGH: rdata_next[7:0] = mark_period_high_reg;
            `OFF_MARK_PERIOD_LOW: rdata_next[7:0] = mark_period_low_reg;
            `OFF_SPACE_PERIOD_HIGH: rdata_next[7:0] = space_period_high_reg;
            `OFF_SPACE_PERIOD_LOW: rdata_next[7:0] = space_period_low_reg;
            `OFF_IRQ_STATUS: rdata_next[1:0] = irq_status_reg;
            `OFF_IRQ_ENABLE: rdata_next[1:0] = irq_enable_reg;
            `OFF_MOD_STATE: rdata_next[1:0] = {mod_out_reg, active_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            pin_output_control_reg <= `RST_PIN_OUTPUT_CONTROL;
            msc_ctrl_reg <= `RST_MSC_CTRL;
            mark_period_high_reg <= `RST_PERIOD;
            mark_period_low_reg <= `RST_PERIOD;
            space_period_high_reg <= `RST_PERIOD;
            space_period_low_reg <= `RST_PERIOD;
            irq_enable_reg <= 2'h0;
        end else if (i_ce && wr_hit) begin
            case (i_address)
                `OFF_PIN_OUTPUT_CONTROL: pin_output_control_reg <= {i_writedata[7:5], 5'h00};
                `OFF_MODULATOR_STATUS_CONTROL: msc_ctrl_reg <= i_writedata[6:0];
                `OFF_MARK_PERIOD_HIGH: mark_period_high_reg <= i_writedata[7:0];
                `OFF_MARK_PERIOD_LOW: mark_period_low_reg <= i_writedata[7:0];
                `OFF_SPACE_PERIOD_HIGH: space_period_high_reg <= i_writedata[7:0];
                `OFF_SPACE_PERIOD_LOW: space_period_low_reg <= i_writedata[7:0];
                `OFF_IRQ_ENABLE: irq_enable_reg <= i_writedata[1:0];
                default: irq_enable_reg <= irq_enable_reg;
            endcase
        end
    end

    // Modulator: mark counts down to zero, then the counter wraps and space runs until it equals the space value
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            active_reg <= 1'b0;
            mod_out_reg <= 1'b0;
            down_counter_reg <= 16'h0000;
            space_period_reg <= 16'h0000;
        end else if (i_ce) begin
            if (start_event) begin
                active_reg <= 1'b1;
                mod_out_reg <= 1'b1;
                down_counter_reg <= {mark_period_high_reg, mark_period_low_reg};
                space_period_reg <= {space_period_high_reg, space_period_low_reg};
            end else if (match) begin
                // Disabled cycle is allowed to expire, then output forced low
                active_reg <= modulator_carrier_enable;
                mod_out_reg <= modulator_carrier_enable;
                down_counter_reg <= {mark_period_high_reg, mark_period_low_reg};
                space_period_reg <= {space_period_high_reg, space_period_low_reg};
            end else if (active_reg && tick) begin
                down_counter_reg <= down_counter_reg - 16'h0001;
                if (down_counter_reg == 16'h0000) begin
                    mod_out_reg <= 1'b0;
                end
            end
        end
    end

    // Flag: set wins over the clear when both land in one cycle
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            end_of_cycle_flag_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (i_ce) begin
            if (start_event || eoc_event) begin
                end_of_cycle_flag_reg <= 1'b1;
            end else if (armed_reg && data_24_access) begin
                end_of_cycle_flag_reg <= 1'b0;
            end
            if (rd_hit && is_reg(i_address, `OFF_MODULATOR_STATUS_CONTROL) && end_of_cycle_flag_reg) begin
                armed_reg <= 1'b1;
            end else if (data_24_access || !end_of_cycle_flag_reg) begin
                armed_reg <= 1'b0;
            end
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            irq_status_reg <= 2'h0;
        end else if (i_ce) begin
            irq_status_reg[`IRQ_EOC] <= eoc_event | (irq_status_reg[`IRQ_EOC] &
                ~(wr_hit & is_reg(i_address, `OFF_IRQ_CLEAR) & i_writedata[`IRQ_EOC]));
            irq_status_reg[`IRQ_START] <= start_event | (irq_status_reg[`IRQ_START] &
                ~(wr_hit & is_reg(i_address, `OFF_IRQ_CLEAR) & i_writedata[`IRQ_START]));
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_infrared_output_pin <= 1'b0;
            o_infrared_output_pin_oe <= 1'b0;
            o_extended_space_enable <= 1'b0;
            o_frequency_shift_select <= 1'b0;
            o_baseband_select <= 1'b0;
            o_modulator_active <= 1'b0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_infrared_output_pin <= pin_output_control_reg[`BIT_POL] ? pin_src : ~pin_src;
            o_infrared_output_pin_oe <= pin_output_control_reg[`BIT_PIN_EN];
            o_extended_space_enable <= msc_ctrl_reg[`BIT_EXTENDED_SPACE_ENABLE];
            o_frequency_shift_select <= msc_ctrl_reg[`BIT_FSK];
            o_baseband_select <= msc_ctrl_reg[`BIT_BASEBAND_SELECT];
            o_modulator_active <= active_reg;
            o_irq <= (end_of_cycle_flag_reg & msc_ctrl_reg[`BIT_END_OF_CYCLE_IRQ_ENABLE]) |
                (|(irq_status_reg & irq_enable_reg));
        end
    end
endmodule

// [verif/ir_mod_asserts.sv]
// Concurrent checks on the bus handshake, pin enable and mode outputs
`timescale 1ns/1ps
module ir_mod_asserts (
    input wire i_clock,
    input wire i_rst_b,
    input wire [3:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [31:0] o_readdata,
    input wire o_waitrequest,
    input wire o_infrared_output_pin_oe,
    input wire o_extended_space_enable,
    input wire o_frequency_shift_select,
    input wire o_baseband_select,
    input wire o_modulator_active,
    input wire o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence req_s;
        $rose(i_read | i_write);
    endsequence
    sequence wr_s(a);
        $rose(i_write) && i_address == a;
    endsequence
    ack_bound_a: assert property (req_s |=> !o_waitrequest)
        else $error("access not answered after one wait state");
    ack_cause_a: assert property ($fell(o_waitrequest) |-> $past(i_read | i_write))
        else $error("answer without a request");
    ack_single_a: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("answer held longer than one cycle");
    idle_data_a: assert property (o_waitrequest |-> o_readdata == 32'h0)
        else $error("read data not zero outside an answer");
    reset_idle_a: assert property ($rose(i_rst_b) |-> !o_infrared_output_pin_oe && !o_irq && !o_modulator_active)
        else $error("outputs not idle after reset");
    pin_enable_a: assert property (wr_s(4'h0) |-> ##3 o_infrared_output_pin_oe == $past(i_writedata[5], 3))
        else $error("pin enable does not follow control write");
    mode_copy_a: assert property (wr_s(4'h1) |-> ##3
        {o_extended_space_enable, o_baseband_select, o_frequency_shift_select} == $past(i_writedata[4:2], 3))
        else $error("mode outputs do not follow status control write");
    start_run_a: assert property (wr_s(4'h1) && i_writedata[0] |-> ##[1:4] o_modulator_active)
        else $error("modulator not running after enable");
endmodule

// [verif/ir_emitter.sv]
// Emitter driver model on the infrared pin, with a pull-down on its input
`timescale 1ns/1ps
module ir_emitter (
    input wire i_clock,
    input wire i_pin,
    input wire i_oe,
    output logic o_level,
    output int o_pulses
);
    logic prev = 1'b0;
    initial o_pulses = 0;
    // Released pin reads low through the pull-down
    assign o_level = i_oe ? i_pin : 1'b0;
    always @(posedge i_clock) begin
        prev <= o_level;
        if (o_level === 1'b1 && prev === 1'b0) o_pulses <= o_pulses + 1;
    end
endmodule

// [verif/ir_modulator_output_status_test.sv]
// Self-checking bench of the infrared modulator output stage
`timescale 1ns/1ps
module ir_modulator_output_status_test;
    logic i_clock = 0, i_rst_b = 0, i_ce = 1, i_read = 0, i_write = 0, i_carrier = 0;
    logic [3:0] i_address = 4'h0;
    logic [31:0] i_writedata = 32'h0, rd, d;
    wire [31:0] o_readdata;
    wire o_waitrequest, o_infrared_output_pin, o_infrared_output_pin_oe, o_extended_space_enable;
    wire o_frequency_shift_select, o_baseband_select, o_modulator_active, o_irq, level;
    int error_cnt = 0, checks = 0, cyc = 0, pulses, p0, tk, df;
    int tm[4];
    ir_modulator_output_status dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_carrier(i_carrier),
        .o_infrared_output_pin(o_infrared_output_pin), .o_infrared_output_pin_oe(o_infrared_output_pin_oe),
        .o_extended_space_enable(o_extended_space_enable), .o_frequency_shift_select(o_frequency_shift_select),
        .o_baseband_select(o_baseband_select), .o_modulator_active(o_modulator_active), .o_irq(o_irq));
    ir_emitter emit_u (.i_clock(i_clock), .i_pin(o_infrared_output_pin), .i_oe(o_infrared_output_pin_oe),
        .o_level(level), .o_pulses(pulses));
    initial forever #25 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        i_carrier <= $urandom;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task final_report();
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // Request held until the edge that samples waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clock);
        i_address <= a;
        i_writedata <= wd;
        i_read <= !w;
        i_write <= w;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(0, 1);
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    initial begin
        void'($urandom(32'h3EFB));
        tick(4);
        i_rst_b <= 1'b1;
        rdc(4'h0, 32'h0);
        rdc(4'h1, 32'h0);
        for (int a = 2; a < 6; a++) rdc(a[3:0], 32'h0);
        wr(4'hF, 32'hFF);
        rdc(4'hF, 32'h0);
        wr(4'h1, 32'h1C);
        tick(3);
        check(o_frequency_shift_select, 1);
        check(o_baseband_select, 1);
        check(o_extended_space_enable, 1);
        check(o_modulator_active, 0);
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            d[7:5] = i[2:0];
            wr(4'h0, d);
            tick(3);
            check(o_infrared_output_pin_oe, d[5]);
            if (d[5]) check(level, d[6] ? d[7] : !d[7]);
            rdc(4'h0, d & 32'hE0);
        end
        wr(4'h0, 32'h60);
        wr(4'h2, 32'hFF);
        wr(4'h3, 32'hFF);
        wr(4'h1, 32'h72);
        check(o_modulator_active, 0);
        wr(4'h1, 32'h73);
        tick(3);
        check(o_modulator_active, 1);
        check(o_irq, 1);
        wr(4'h5, 32'h0);
        rdc(4'h1, 32'hF3);
        wr(4'h3, 32'hFF);
        tick(2);
        check(o_irq, 0);
        rdc(4'h1, 32'h73);
        wr(4'h1, 32'h71);
        tick(2);
        check(o_irq, 0);
        wr(4'h7, 32'h2);
        tick(2);
        check(o_irq, 1);
        bus(1'b0, 4'h6, 32'h0);
        check(rd[1], 1);
        wr(4'h8, 32'h2);
        tick(2);
        check(o_irq, 0);
        wr(4'h1, 32'h70);
        tick(2);
        check(o_modulator_active, 1);
        wr(4'h1, 32'h71);
        rdc(4'h1, 32'h71);
        i_rst_b <= 1'b0;
        tick(2);
        check(o_infrared_output_pin_oe, 0);
        i_rst_b <= 1'b1;
        wr(4'h0, 32'h60);
        wr(4'h3, 32'h10);
        p0 = pulses;
        for (int k = 0; k < 4; k++) begin
            wr(4'h1, (k << 5) | 9);
            wr(4'h1, k << 5);
            tk = 0;
            while (o_modulator_active !== 1'b0 && tk < 3000) begin
                tick(1);
                tk++;
            end
            tm[k] = tk;
        end
        check(pulses > p0, 1);
        check(tm[1] - tm[0] > 8, 1);
        for (int k = 2; k < 4; k++) begin
            df = (tm[k] - tm[0]) - ((1 << k) - 1) * (tm[1] - tm[0]);
            check(df < 9 && df > -9, 1);
        end
        wr(4'h1, 32'h01);
        bus(1'b0, 4'h1, 32'h0);
        wr(4'h5, 32'h0);
        tick(60);
        bus(1'b0, 4'h1, 32'h0);
        check(rd[7], 1);
        final_report();
    end
endmodule
bind ir_modulator_output_status ir_mod_asserts chk_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_infrared_output_pin_oe(o_infrared_output_pin_oe),
    .o_extended_space_enable(o_extended_space_enable), .o_frequency_shift_select(o_frequency_shift_select),
    .o_baseband_select(o_baseband_select), .o_modulator_active(o_modulator_active), .o_irq(o_irq));
